/* rtl/dcwd_regs.vh */
// Command word bit positions, state codes and status bit positions for the command decoder
`ifndef DCWD_REGS_VH
`define DCWD_REGS_VH

`define DCWD_CMD_ON          0
`define DCWD_CMD_COAST_RSV   1
`define DCWD_CMD_QUICK_RSV   2
`define DCWD_CMD_OP_EN       3
`define DCWD_CMD_NO_STOP     4
`define DCWD_CMD_NO_PAUSE    5
`define DCWD_CMD_RUN_TOGGLE  6
`define DCWD_CMD_FAULT_ACK   7
`define DCWD_CMD_JOG1        8
`define DCWD_CMD_JOG2        9
`define DCWD_CMD_REMOTE      10
`define DCWD_CMD_SPEED_MODE  12
`define DCWD_CMD_RESERVED    16'hE806
`define DCWD_CMD_RESET       16'h0000

`define DCWD_ST_RDY_ON       0
`define DCWD_ST_RDY_OP       1
`define DCWD_ST_OP_EN        2
`define DCWD_ST_FAULT        3
`define DCWD_ST_INHIBIT      6
`define DCWD_ST_ACK          12
`define DCWD_ST_STILL        13

`define DCWD_S_NOT_READY     3'h0
`define DCWD_S_READY_ON      3'h1
`define DCWD_S_READY_OP      3'h2
`define DCWD_S_OP_EN         3'h3
`define DCWD_S_FAULT         3'h4
`define DCWD_S_INHIBIT       3'h5

`endif

/* rtl/dcwd_decoder.v */
// Command word decoder: power-up state machine, run handshake, stops, jog and fault acknowledge
`timescale 1ns/100ps
`include "dcwd_regs.vh"

module dcwd_decoder
(
	core_clk,
	rstn,
	clk_en,
	cmd_word,
	cmd_valid,
	fault_in,
	at_range_end,
	move_done,
	drive_state_word,
	drive_state,
	run_active,
	run_paused,
	run_speed_mode,
	run_clockwise,
	run_endless,
	run_start,
	jog1_start,
	jog2_start,
	halt_now,
	cmd_reserved_err
);
	input  wire        core_clk;
	input  wire        rstn;
	input  wire        clk_en;
	input  wire [15:0] cmd_word;
	input  wire        cmd_valid;
	input  wire        fault_in;
	input  wire        at_range_end;
	input  wire        move_done;
	output wire [15:0] drive_state_word;
	output wire [2:0]  drive_state;
	output reg         run_active;
	output reg         run_paused;
	output reg         run_speed_mode;
	output reg         run_clockwise;
	output reg         run_endless;
	output reg         run_start;
	output reg         jog1_start;
	output reg         jog2_start;
	output reg         halt_now;
	output reg         cmd_reserved_err;

	reg [15:0] cmd_q;
	reg [15:0] prev_q;
	reg        upd_q;
	reg [2:0]  state_q;
	reg [2:0]  state_d;
	reg        ack_q;
	reg        inhibit_q;
	reg        still_q;

	wire on_w      = cmd_q[`DCWD_CMD_ON];
	wire op_w      = cmd_q[`DCWD_CMD_OP_EN];
	wire remote_w  = cmd_q[`DCWD_CMD_REMOTE];
	wire nostop_w  = cmd_q[`DCWD_CMD_NO_STOP];
	wire nopause_w = cmd_q[`DCWD_CMD_NO_PAUSE];
	wire tog_w     = cmd_q[`DCWD_CMD_RUN_TOGGLE];
	wire speed_w   = cmd_q[`DCWD_CMD_SPEED_MODE];

	// Edge test between the two most recent updates
	function edge_of;
		input [15:0] cur;
		input [15:0] prv;
		input integer bitn;
		input         rising;
		begin
			edge_of = rising ? (cur[bitn] & ~prv[bitn]) : (~cur[bitn] & prv[bitn]);
		end
	endfunction

	wire ack_fall   = upd_q & edge_of(cmd_q, prev_q, `DCWD_CMD_FAULT_ACK, 1'b0);
	wire on_fall    = upd_q & edge_of(cmd_q, prev_q, `DCWD_CMD_ON, 1'b0);
	wire tog_rise   = upd_q & edge_of(cmd_q, prev_q, `DCWD_CMD_RUN_TOGGLE, 1'b1);
	wire tog_fall   = upd_q & edge_of(cmd_q, prev_q, `DCWD_CMD_RUN_TOGGLE, 1'b0);
	wire jog1_rise  = upd_q & edge_of(cmd_q, prev_q, `DCWD_CMD_JOG1, 1'b1);
	wire jog2_rise  = upd_q & edge_of(cmd_q, prev_q, `DCWD_CMD_JOG2, 1'b1);
	wire enabled_w  = (state_q == `DCWD_S_OP_EN);
	wire pos_req    = enabled_w & ~speed_w & nostop_w & (tog_w != ack_q) & ~run_active;
	wire spd_req    = enabled_w & speed_w & tog_rise & ~run_active;

	// Each cyclic update seen while clk_en is high is captured once, previous kept for edges
	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			cmd_q  <= `DCWD_CMD_RESET;
			prev_q <= `DCWD_CMD_RESET;
			upd_q  <= 1'b0;
		end
		else if (clk_en)
		begin
			upd_q <= cmd_valid;
			if (cmd_valid)
			begin
				prev_q <= cmd_q;
				cmd_q  <= cmd_word;
			end
		end
	end

	always @*
	begin
		state_d = state_q;
		case (state_q)
			`DCWD_S_NOT_READY:
				if (remote_w)
					state_d = `DCWD_S_READY_ON;
			`DCWD_S_READY_ON:
				if (!remote_w)
					state_d = `DCWD_S_NOT_READY;
				else if (on_w)
					state_d = `DCWD_S_READY_OP;
			`DCWD_S_READY_OP:
				if (!remote_w)
					state_d = `DCWD_S_NOT_READY;
				else if (!on_w)
					state_d = `DCWD_S_READY_ON;
				else if (fault_in)
					state_d = `DCWD_S_FAULT;
				else if (op_w)
					state_d = `DCWD_S_OP_EN;
			`DCWD_S_OP_EN:
				if (!remote_w)
					state_d = `DCWD_S_NOT_READY;
				else if (!on_w)
					state_d = `DCWD_S_READY_ON;
				else if (fault_in)
					state_d = `DCWD_S_FAULT;
				else if (!op_w)
					state_d = `DCWD_S_READY_OP;
			`DCWD_S_FAULT:
				if (ack_fall)
					state_d = `DCWD_S_INHIBIT;
			`DCWD_S_INHIBIT:
				if (on_fall || !remote_w)
					state_d = remote_w ? `DCWD_S_READY_ON : `DCWD_S_NOT_READY;
			default:
				state_d = `DCWD_S_NOT_READY;
		endcase
	end

	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			state_q   <= `DCWD_S_NOT_READY;
			inhibit_q <= 1'b0;
			ack_q     <= 1'b0;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
			// Set wins over clear when both land together
			if (state_q == `DCWD_S_FAULT && ack_fall)
				inhibit_q <= 1'b1;
			else if (on_fall)
				inhibit_q <= 1'b0;
			if (state_q == `DCWD_S_NOT_READY || state_q == `DCWD_S_READY_ON)
				ack_q <= 1'b0;
			else if (pos_req || spd_req)
				ack_q <= tog_w;
		end
	end

	// Run control: start, pause, abort, speed direction and end
	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			run_active     <= 1'b0;
			run_paused     <= 1'b0;
			run_speed_mode <= 1'b0;
			run_clockwise  <= 1'b0;
			run_endless    <= 1'b0;
			run_start      <= 1'b0;
			jog1_start     <= 1'b0;
			jog2_start     <= 1'b0;
			halt_now       <= 1'b0;
			still_q        <= 1'b1;
			cmd_reserved_err <= 1'b0;
		end
		else if (clk_en)
		begin
			run_start  <= pos_req | spd_req;
			jog1_start <= enabled_w & jog1_rise & ~run_active;
			jog2_start <= enabled_w & jog2_rise & ~run_active;
			cmd_reserved_err <= |(cmd_q & `DCWD_CMD_RESERVED);
			halt_now   <= 1'b0;
			if (!enabled_w)
			begin
				run_active <= 1'b0;
				run_paused <= 1'b0;
				halt_now   <= run_active;
			end
			else if (pos_req)
			begin
				run_active     <= 1'b1;
				run_speed_mode <= 1'b0;
				run_paused     <= ~nopause_w;
			end
			else if (spd_req)
			begin
				run_active     <= 1'b1;
				run_speed_mode <= 1'b1;
				run_clockwise  <= nostop_w;
				run_endless    <= nopause_w;
				run_paused     <= 1'b0;
			end
			else if (run_active && run_speed_mode)
			begin
				run_endless <= nopause_w;
				if (tog_fall || move_done || (!nopause_w && at_range_end))
				begin
					run_active <= 1'b0;
					halt_now   <= 1'b1;
				end
			end
			else if (run_active)
			begin
				if (!nostop_w)
				begin
					run_active <= 1'b0;
					run_paused <= 1'b0;
					halt_now   <= 1'b1;
				end
				else if (move_done)
					run_active <= 1'b0;
				else
				begin
					run_paused <= ~nopause_w;
					halt_now   <= ~nopause_w & ~run_paused;
				end
			end
			if (pos_req || spd_req)
				still_q <= 1'b0;
			else if (!run_active)
				still_q <= 1'b1;
		end
	end

	assign drive_state = state_q;
	assign drive_state_word = {
		2'b00,
		still_q,
		ack_q,
		5'b0_0000,
		inhibit_q,
		2'b00,
		(state_q == `DCWD_S_FAULT),
		enabled_w,
		(state_q == `DCWD_S_READY_OP) | enabled_w,
		(state_q == `DCWD_S_READY_ON) | (state_q == `DCWD_S_READY_OP) | enabled_w
	};

endmodule

/* bench/dcwd_monitor.sv */
// Port checker for the command word decoder
`timescale 1ns/100ps
module dcwd_monitor
(
	input wire        core_clk,
	input wire        rstn,
	input wire [15:0] cmd_word,
	input wire        cmd_valid,
	input wire [15:0] drive_state_word,
	input wire [2:0]  drive_state,
	input wire        run_active,
	input wire        run_paused,
	input wire        run_speed_mode,
	input wire        run_start,
	input wire        jog1_start,
	input wire        jog2_start,
	input wire        cmd_reserved_err
);
	reg [15:0] last_q;
	// Last update taken from the controller
	always @(posedge core_clk)
		if (!rstn)
			last_q <= 16'h0000;
		else if (cmd_valid)
			last_q <= cmd_word;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	AST_UP_REMOTE: assert property ($past(drive_state) == 3'h0 && drive_state == 3'h1 |-> last_q[10])
		else $error("ready-on entered without bit 10");
	AST_UP_ON: assert property ($past(drive_state) == 3'h1 && drive_state == 3'h2 |-> last_q[0] && last_q[10])
		else $error("ready-op entered without bits 0 and 10");
	AST_UP_OPEN: assert property ($past(drive_state) == 3'h2 && drive_state == 3'h3 |-> last_q[3] && last_q[0] && last_q[10])
		else $error("op-enabled entered without bits 3, 0 and 10");
	AST_RDY_FLAG: assert property (drive_state == 3'h1 |-> drive_state_word[0])
		else $error("ready-on status bit clear");
	AST_DROP: assert property (drive_state inside {3'h1, 3'h2, 3'h3} && !last_q[10] |-> ##[0:3] drive_state == 3'h0)
		else $error("bit 10 clear did not drop state");
	AST_RESV: assert property (cmd_valid && |(cmd_word & 16'hE806) |-> ##[1:2] cmd_reserved_err)
		else $error("reserved bit not flagged");
	AST_ACK: assert property (run_start |-> drive_state_word[12] == last_q[6] ##1 !run_start)
		else $error("ack bit differs at run start");
	AST_STOP: assert property ($fell(last_q[4]) && run_active && !run_speed_mode |-> ##[1:3] !run_active)
		else $error("run kept after bit 4 clear");
	AST_PAUSE: assert property ($fell(last_q[5]) && run_active && !run_speed_mode |-> ##[1:3] run_paused)
		else $error("no pause after bit 5 clear");
	AST_JOG1: assert property (jog1_start |-> last_q[8] && drive_state == 3'h3)
		else $error("jog one without bit 8");
	AST_JOG2: assert property (jog2_start |-> last_q[9] && drive_state == 3'h3)
		else $error("jog two without bit 9");
endmodule

/* bench/dcwd_plc_model.sv */
// Cyclic command word source standing in for the controller
`timescale 1ns/100ps
module dcwd_plc_model
(
	input wire        core_clk,
	output reg [15:0] cmd_word,
	output reg        cmd_valid
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_word  = 16'hFFFF;
	end
	// One update per call; word is scrambled outside the valid cycle
	task send(input [15:0] w);
		@(posedge core_clk);
		#1;
		cmd_word  = w;
		cmd_valid = 1'b1;
		@(posedge core_clk);
		#1;
		cmd_valid = 1'b0;
		cmd_word  = ~w;
	endtask
endmodule

/* bench/tb_top.sv */
// Self-checking testbench for the command word decoder
`timescale 1ns/100ps
module tb_top;
	reg         core_clk = 0;
	reg         rstn = 0;
	reg         fault_in = 0;
	reg         at_range_end = 0;
	reg         move_done = 0;
	reg         ce = 1;
	reg         seen_j1 = 0;
	reg         seen_j2 = 0;
	reg         seen_halt = 0;
	integer     n_mismatch = 0;
	integer     n_checks = 0;
	wire [15:0] cmd_word;
	wire        cmd_valid;
	wire [15:0] dsw;
	wire [2:0]  st;
	wire        r_act, r_pau, r_spd, r_cw, r_end, r_go, j1, j2, halt, rsv;
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		if (j1 === 1'b1) seen_j1 <= 1;
		if (j2 === 1'b1) seen_j2 <= 1;
		if (halt === 1'b1) seen_halt <= 1;
	end
	dcwd_plc_model plc(.core_clk(core_clk), .cmd_word(cmd_word), .cmd_valid(cmd_valid));
	dcwd_decoder dut(.core_clk(core_clk), .rstn(rstn), .clk_en(ce), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
		.fault_in(fault_in), .at_range_end(at_range_end), .move_done(move_done), .drive_state_word(dsw),
		.drive_state(st), .run_active(r_act), .run_paused(r_pau), .run_speed_mode(r_spd), .run_clockwise(r_cw),
		.run_endless(r_end), .run_start(r_go), .jog1_start(j1), .jog2_start(j2), .halt_now(halt),
		.cmd_reserved_err(rsv));
	task chk(input [15:0] s, input [15:0] e);
		n_checks = n_checks + 1;
		if (s !== e)
		begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task settle;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	task upd(input [15:0] w);
		plc.send(w);
		settle;
	endtask
	task t_power;
		chk(dsw, 16'h2000);
		ce = 0;
		upd(16'h0400); chk({st, dsw[0]}, {3'h0, 1'b0});
		ce = 1;
		settle; chk(st, 3'h0);
		upd(16'h0400); chk({st, dsw[0]}, {3'h1, 1'b1});
		upd(16'h0401); chk({st, dsw[2:0]}, {3'h2, 3'b011});
		upd(16'h0409); chk({st, dsw[2:0]}, {3'h3, 3'b111});
		upd(16'h0401); chk(st, 3'h2);
		upd(16'h0409); chk(st, 3'h3);
	endtask
	task t_pos;
		upd(16'h0479); chk({r_act, r_spd, dsw[12], dsw[13]}, 4'b1010);
		upd(16'h0459); chk(r_pau, 1'b1);
		upd(16'h0479); chk({r_act, r_pau}, 2'b10);
		seen_halt = 0;
		upd(16'h0469); chk({r_act, seen_halt}, 2'b01);
		upd(16'h0439); chk({r_act, dsw[12]}, 2'b10);
		upd(16'h0429); chk(r_act, 1'b0);
		upd(16'h0439); chk(r_act, 1'b0);
	endtask
	task t_speed;
		upd(16'h1419);
		upd(16'h1459); chk({r_act, r_spd, r_cw, r_end}, 4'b1110);
		at_range_end = 1;
		settle; chk(r_act, 1'b0);
		at_range_end = 0;
		upd(16'h1419);
		upd(16'h1469); chk({r_act, r_spd, r_cw, r_end}, 4'b1101);
		upd(16'h1429); chk(r_act, 1'b0);
		upd(16'h0409);
	endtask
	task pulse_done;
		move_done = 1;
		@(posedge core_clk);
		#1;
		move_done = 0;
	endtask
	task t_jog;
		upd(16'h0509); chk(seen_j1, 1'b1);
		pulse_done;
		upd(16'h0409);
		upd(16'h0609); chk(seen_j2, 1'b1);
		pulse_done;
		upd(16'h0409);
	endtask
	task t_fault;
		fault_in = 1;
		settle; chk({st, dsw[3]}, {3'h4, 1'b1});
		fault_in = 0;
		upd(16'h0489);
		upd(16'h0409); chk({st, dsw[6], dsw[3]}, {3'h5, 2'b10});
		upd(16'h0408); chk({st, dsw[6]}, {3'h1, 1'b0});
	endtask
	task t_resv;
		upd(16'h0C00); chk(rsv, 1'b1);
		upd(16'h0000); chk({rsv, st}, 4'h0);
	endtask
	task end_of_test;
		if (n_mismatch == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge core_clk);
		#1;
		rstn = 1;
		t_power;
		t_pos;
		t_speed;
		t_jog;
		t_fault;
		t_resv;
		end_of_test;
	end
	initial
	begin
		#400000;
		n_mismatch = n_mismatch + 1;
		end_of_test;
	end
endmodule
bind dcwd_decoder dcwd_monitor mon(.core_clk(core_clk), .rstn(rstn), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
	.drive_state_word(drive_state_word), .drive_state(drive_state), .run_active(run_active),
	.run_paused(run_paused), .run_speed_mode(run_speed_mode), .run_start(run_start), .jog1_start(jog1_start),
	.jog2_start(jog2_start), .cmd_reserved_err(cmd_reserved_err));
